// ---- rtl/spift_pkg.sv ----
// Purpose: shared constants and types for the serial frame supervisor
// Assumes: 10 MHz system clock, 24-bit frame words, 16-bit register data
// Notes: command codes other than the read and write opcodes are local picks
`default_nettype none

package spift_pkg;

  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam logic [4:0] BIT_LAST = 5'h17;
  localparam logic [5:0] WORD_MAX = 6'h3f;
  localparam logic [5:0] WORD_CMD = 6'h00;
  localparam logic [5:0] WORD_CMD_CRC = 6'h01;
  localparam logic [5:0] WORD_SHUNT_B = 6'h02;
  localparam logic [5:0] WORD_OUT_CRC = 6'h03;
  localparam logic [5:0] WORD_WR_FIRST = 6'h02;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  localparam logic [2:0] RD_OPCODE = 3'h5;
  localparam logic [2:0] WR_OPCODE = 3'h3;
  localparam logic [15:0] NOOP_CMD = 16'h0000;
  localparam logic [15:0] RESET_CMD = 16'h0011;
  localparam logic [15:0] LOCK_CMD = 16'h0555;
  localparam logic [15:0] UNLOCK_CMD = 16'h0655;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IDENT = 8'h00;
  localparam logic [7:0] ADDR_STAT_HI = 8'h01;
  localparam logic [7:0] ADDR_STAT_LO = 8'h02;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h09;
  localparam logic [7:0] ADDR_MUX_BASE = 8'h10;
  localparam logic [7:0] SEC0_LAST = 8'h1f;
  localparam logic [7:0] SEC1_FIRST = 8'h40;
  localparam logic [7:0] SEC2_FIRST = 8'h80;
  localparam logic [7:0] SEC3_FIRST = 8'hc0;
  localparam int MUX_STEPS = 16;
  localparam logic [3:0] MUX_LAST = 4'hf;
  localparam logic [15:0] STAT_HI_RST = 16'h7fc8;
  localparam int RST_FLAG_BIT = 15;
  localparam int OVT_FLAG_BIT = 9;
  localparam logic [15:0] RESTART_MASK = 16'h5000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int READY_PULSE_NS = 400;
  localparam int READY_PULSE_CYC_I = (READY_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] READY_PULSE_CYC = 4'(READY_PULSE_CYC_I);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
  } spift_result_t;

  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_ACTIVE = 2'b01,
    FR_OVERTIME = 2'b10
  } spift_frame_t;

endpackage : spift_pkg

`default_nettype wire

// ---- rtl/spift_sync.sv ----
// Purpose: two-flop synchroniser with edge pulses on the synchronised level
// Assumes: input is asynchronous to clk
// Notes: the first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none

module spift_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin side
  input wire logic din,
  // clock side
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule : spift_sync

`default_nettype wire

// ---- rtl/spift_top.sv ----
// Purpose: serial frame supervisor, result routing and sample-ready pin
// Assumes: link pins oversampled by clk; data launched on serial_clk rise, sampled on fall
// Notes: checksum words are not verified; output checksum word is sent as zero
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: time frame_select_n low; overlong frame sets overtime flag in next status.
// R2: after timeout ignore further input bits until frame_select_n rises.
// R3: overtime_check_enable switches supervision; disabled means no flag.
// R4: timeout after a complete frame leaves traffic intact but still flags.
// R5: reset command executes only after whole output checksum word shifted out.
// R6: lock, unlock, read execute once command and its checksum arrived in time.
// R7: write executes only after command, checksum, data and data checksum arrived.
// R8: on timeout sample_ready_n rises only if shunt_adc_b word already went out.
// R9: shunt_adc_a and shunt_adc_b results reply to a no-op in the next frame.
// R10: mux_adc step results live at consecutive registers from 10h.
// R11: one read frame returns up to 32 consecutive registers.
// R12: sample_ready_n falls on new conversion of the selected shunt converter.
// R13: if already low, pulse sample_ready_n high for pulse width before falling.
// R14: sample_ready_n rises once the shunt_adc_b word was shifted out.
// R15: frame ending before shunt_adc_b word leaves sample_ready_n low.
// R16: same results readable repeatedly; per-converter counters in status.
// R17: results completing mid-read are held, loaded next frame, ready stays low.
// R18: writing conversion_restart raises sample_ready_n at end of data checksum word.
// R19: after restart the previous results stay readable until new ones arrive.
// R20: register space has four sections; only section 0 answers reads here.
// R21: host treats unlisted addresses as reserved and leaves them unmodified.
// R22: frame after a read shifts out registers ascending instead of results.
// R23: host sends no-op in the frame after a read; other commands ignored.
// R24: timeout counter clears at frame start and counts to a build parameter.
// R25: active-low flags show zero on fault, return to one only on status clear.
module spift_top
  import spift_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = 200000,
  parameter logic [15:0] IDENT_WORD = 16'h5a21 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link pins
  input wire logic frame_select_n,
  input wire logic serial_clk,
  input wire logic serial_din,
  output logic serial_dout,
  output logic sample_ready_n,
  // shunt converter results
  input wire logic shunt_a_done,
  input wire logic [WORD_W-1:0] shunt_a_data,
  input wire logic shunt_b_done,
  input wire logic [WORD_W-1:0] shunt_b_data,
  // mux converter step results
  input wire logic mux_step_we,
  input wire logic [3:0] mux_step_idx,
  input wire logic [15:0] mux_step_data,
  // configuration and status control
  input wire logic overtime_check_enable,
  input wire logic ready_source_select,
  input wire logic status_clear,
  // command effects
  output logic conversion_restart,
  output logic device_reset_req,
  output logic lock_req,
  output logic unlock_req
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_rise, cs_fall;
  logic sclk_rise, sclk_fall;
  logic sdi_s;

  spift_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk(clk), .rst(rst), .din(frame_select_n),
    .level(), .rise(cs_rise), .fall(cs_fall)
  );
  spift_sync #(.RST_VAL(1'b0)) u_sync_sclk (
    .clk(clk), .rst(rst), .din(serial_clk),
    .level(), .rise(sclk_rise), .fall(sclk_fall)
  );
  spift_sync #(.RST_VAL(1'b0)) u_sync_sdi (
    .clk(clk), .rst(rst), .din(serial_din),
    .level(sdi_s), .rise(), .fall()
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spift_frame_t state_q;
  logic [31:0] tmo_cnt_q;
  logic tmo_hit;
  logic [4:0] bit_q;
  logic [5:0] word_q;
  logic [WORD_W-1:0] rx_q, rx_d, tx_q;
  logic word_done, b_sent;
  logic [15:0] cmd_q;
  logic rd_pend_q, rd_frame_q, wr_act_q, restart_arm_q;
  logic [7:0] rd_addr_q;
  logic [4:0] rd_n_q;
  logic [5:0] wr_last;
  logic [7:0] wr_addr;
  logic sdo_q, ready_n_q;
  logic [3:0] pw_cnt_q;
  logic new_sel;
  logic rst_flag_n_q, ovt_flag_n_q;
  spift_result_t hold_q, out_q;
  logic res_pend_q;
  logic [1:0] cnt_a_q, cnt_b_q, cnt_mux_q;
  logic [15:0] mux_mem_q [MUX_STEPS];
  logic [15:0] stat_hi, stat_lo;

  assign serial_dout = sdo_q;
  assign sample_ready_n = ready_n_q;

  // ----------------------------------------------------------------
  // frame supervision
  // ----------------------------------------------------------------
  assign tmo_hit = (state_q == FR_ACTIVE) && overtime_check_enable && !cs_rise
                   && (tmo_cnt_q == TIMEOUT_CYC - 1); // [R1] [R3] [R4]

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= FR_IDLE;
    else
    begin
      case (state_q)
        FR_IDLE: if (cs_fall) state_q <= FR_ACTIVE;
        FR_ACTIVE:
          if (cs_rise)
            state_q <= FR_IDLE;
          else if (tmo_hit)
            state_q <= FR_OVERTIME; // [R2]
        FR_OVERTIME: if (cs_rise) state_q <= FR_IDLE; // [R2]
        default: state_q <= FR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || cs_fall)
      tmo_cnt_q <= 32'h0; // [R24]
    else if (state_q == FR_ACTIVE && tmo_cnt_q != TIMEOUT_CYC - 1)
      tmo_cnt_q <= tmo_cnt_q + 32'h1; // [R24]
  end

  // active-low flags: event wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rst_flag_n_q <= 1'b0;
      ovt_flag_n_q <= 1'b1;
    end
    else
    begin
      if (status_clear)
        rst_flag_n_q <= 1'b1; // [R25]
      if (tmo_hit)
        ovt_flag_n_q <= 1'b0; // [R1] [R25]
      else if (status_clear)
        ovt_flag_n_q <= 1'b1; // [R25]
    end
  end

  // ----------------------------------------------------------------
  // bit and word engine
  // ----------------------------------------------------------------
  assign rx_d = {rx_q[WORD_W-2:0], sdi_s};
  assign word_done = sclk_fall && (state_q == FR_ACTIVE) && (bit_q == BIT_LAST)
                     && !tmo_hit; // [R2] [R5]
  assign b_sent = word_done && (word_q == WORD_SHUNT_B) && !rd_frame_q; // [R8]

  always_ff @(posedge clk)
  begin
    if (rst || cs_fall)
    begin
      bit_q <= 5'h0;
      word_q <= 6'h0;
      rx_q <= '0;
    end
    else if (sclk_fall && state_q == FR_ACTIVE) // [R2]
    begin
      rx_q <= rx_d;
      if (bit_q == BIT_LAST)
      begin
        bit_q <= 5'h0;
        if (word_q != WORD_MAX)
          word_q <= word_q + 6'h1;
      end
      else
        bit_q <= bit_q + 5'h1;
    end
  end

  // ----------------------------------------------------------------
  // register file view
  // ----------------------------------------------------------------
  assign stat_hi = {rst_flag_n_q, STAT_HI_RST[14:10], ovt_flag_n_q, STAT_HI_RST[8:0]};
  assign stat_lo = {cnt_mux_q, 2'h0, cnt_a_q, cnt_b_q, 8'h00}; // [R16]

  function automatic logic [WORD_W-1:0] reg_reply(input logic [7:0] a);
    logic [15:0] d;
    logic ok;
    d = 16'h0000;
    ok = 1'b1;
    if (a == ADDR_IDENT)
      d = IDENT_WORD;
    else if (a == ADDR_STAT_HI)
      d = stat_hi;
    else if (a == ADDR_STAT_LO)
      d = stat_lo;
    else if (a == ADDR_CONV_CTRL)
      d = 16'h0000;
    else if (a >= ADDR_MUX_BASE && a <= SEC0_LAST)
      d = mux_mem_q[a[3:0]]; // [R10]
    else
      ok = 1'b0; // [R20]
    return ok ? {d, a} : '0;
  endfunction : reg_reply

  function automatic logic [WORD_W-1:0] tx_word(input logic [5:0] idx);
    logic [5:0] rd_end;
    rd_end = {1'b0, rd_n_q} + 6'h1;
    if (idx == WORD_CMD)
      return {stat_hi, 8'h00};
    if (!rd_frame_q)
    begin
      if (idx == 6'h1)
        return out_q.a; // [R9]
      if (idx == WORD_SHUNT_B)
        return out_q.b; // [R9]
      return '0;
    end
    if (idx <= rd_end)
      return reg_reply(rd_addr_q + {2'b00, idx - 6'h1}); // [R22] [R11]
    return '0;
  endfunction : tx_word

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_q <= '0;
      sdo_q <= 1'b0;
    end
    else if (cs_fall)
      tx_q <= tx_word(WORD_CMD);
    else if (word_done)
      tx_q <= tx_word(word_q + 6'h1);
    else if (sclk_rise && state_q == FR_ACTIVE)
    begin
      sdo_q <= tx_q[WORD_W-1];
      tx_q <= {tx_q[WORD_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------
  assign wr_last = WORD_OUT_CRC + {3'b000, cmd_q[2:0]};
  assign wr_addr = cmd_q[12:5] + {2'b00, word_q - WORD_WR_FIRST};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_q <= NOOP_CMD;
      rd_pend_q <= 1'b0;
      rd_frame_q <= 1'b0;
      rd_addr_q <= 8'h00;
      rd_n_q <= 5'h0;
      wr_act_q <= 1'b0;
      restart_arm_q <= 1'b0;
      conversion_restart <= 1'b0;
      device_reset_req <= 1'b0;
      lock_req <= 1'b0;
      unlock_req <= 1'b0;
    end
    else
    begin
      conversion_restart <= 1'b0;
      device_reset_req <= 1'b0;
      lock_req <= 1'b0;
      unlock_req <= 1'b0;
      if (cs_fall)
      begin
        rd_frame_q <= rd_pend_q; // [R22]
        rd_pend_q <= 1'b0;
        wr_act_q <= 1'b0;
        restart_arm_q <= 1'b0;
        cmd_q <= NOOP_CMD;
      end
      else if (word_done)
      begin
        if (word_q == WORD_CMD)
          cmd_q <= rx_d[WORD_W-1:8];
        if (word_q == WORD_CMD_CRC && !rd_frame_q) // [R6] [R23]
        begin
          if (cmd_q[15:13] == RD_OPCODE)
          begin
            rd_pend_q <= 1'b1;
            rd_addr_q <= cmd_q[12:5];
            rd_n_q <= cmd_q[4:0];
          end
          else if (cmd_q == LOCK_CMD)
            lock_req <= 1'b1;
          else if (cmd_q == UNLOCK_CMD)
            unlock_req <= 1'b1;
          else if (cmd_q[15:13] == WR_OPCODE)
            wr_act_q <= 1'b1;
        end
        if (wr_act_q && word_q == wr_last)
        begin
          wr_act_q <= 1'b0;
          conversion_restart <= restart_arm_q; // [R7] [R18]
        end
        else if (wr_act_q && wr_addr == ADDR_CONV_CTRL
                 && (rx_d[WORD_W-1:8] & RESTART_MASK) != 16'h0000)
          restart_arm_q <= 1'b1;
        if (word_q == WORD_OUT_CRC && !rd_frame_q && cmd_q == RESET_CMD)
          device_reset_req <= 1'b1; // [R5]
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion results
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_q <= '0;
      out_q <= '0;
      res_pend_q <= 1'b0;
      cnt_a_q <= 2'h0;
      cnt_b_q <= 2'h0;
    end
    else
    begin
      if (shunt_a_done)
      begin
        hold_q.a <= shunt_a_data; // [R17]
        cnt_a_q <= cnt_a_q + 2'h1; // [R16]
      end
      if (shunt_b_done)
      begin
        hold_q.b <= shunt_b_data; // [R17]
        cnt_b_q <= cnt_b_q + 2'h1; // [R16]
      end
      if (cs_fall && res_pend_q)
        out_q <= hold_q; // [R17] [R19]
      if (shunt_a_done || shunt_b_done)
        res_pend_q <= 1'b1;
      else if (cs_fall)
        res_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_mux_q <= 2'h0;
      for (int i = 0; i < MUX_STEPS; i++)
        mux_mem_q[i] <= 16'h0000;
    end
    else if (mux_step_we)
    begin
      mux_mem_q[mux_step_idx] <= mux_step_data; // [R10]
      if (mux_step_idx == MUX_LAST)
        cnt_mux_q <= cnt_mux_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // sample ready pin
  // ----------------------------------------------------------------
  assign new_sel = ready_source_select ? shunt_b_done : shunt_a_done;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ready_n_q <= 1'b1;
      pw_cnt_q <= 4'h0;
    end
    else if (new_sel)
    begin
      if (!ready_n_q)
      begin
        ready_n_q <= 1'b1; // [R13]
        pw_cnt_q <= READY_PULSE_CYC;
      end
      else
        ready_n_q <= 1'b0; // [R12]
    end
    else if (pw_cnt_q != 4'h0)
    begin
      pw_cnt_q <= pw_cnt_q - 4'h1;
      if (pw_cnt_q == 4'h1)
        ready_n_q <= 1'b0; // [R13]
    end
    else if (conversion_restart)
      ready_n_q <= 1'b1; // [R18]
    else if (b_sent && !res_pend_q)
      ready_n_q <= 1'b1; // [R14] [R15] [R8]
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_overtime_flag_set: assert property ( // [R1]
    tmo_hit |=> !ovt_flag_n_q && state_q == FR_OVERTIME)
    else $error("overtime flag not set after timeout");
  chk_ignore_after_tmo: assert property ( // [R2]
    state_q == FR_OVERTIME && !cs_fall |=> $stable(word_q) && $stable(bit_q))
    else $error("bits counted after timeout");
  chk_supervise_off: assert property ( // [R3]
    !overtime_check_enable && ovt_flag_n_q |=> ovt_flag_n_q)
    else $error("timeout flag raised while disabled");
  chk_reset_exec: assert property ( // [R5]
    device_reset_req |-> $past(word_q) == WORD_OUT_CRC && state_q != FR_OVERTIME)
    else $error("reset command executed early");
  chk_rd_exec: assert property ( // [R6]
    $rose(rd_pend_q) |-> $past(word_q) == WORD_CMD_CRC && $past(state_q) == FR_ACTIVE)
    else $error("read accepted outside command checksum word");
  chk_wr_exec: assert property ( // [R7]
    conversion_restart |-> $past(word_q) == $past(wr_last) && $past(state_q) == FR_ACTIVE)
    else $error("write executed before data checksum");
  chk_restart_ready: assert property ( // [R18]
    conversion_restart && !new_sel && pw_cnt_q == 4'h0 |=> sample_ready_n)
    else $error("ready not raised by restart");
  chk_ready_pulse: assert property ( // [R13]
    new_sel && !sample_ready_n ##1 !new_sel [*4]
    |-> sample_ready_n && $past(sample_ready_n, 3) ##1 !sample_ready_n)
    else $error("ready pulse width wrong");
  chk_ready_fall: assert property ( // [R12]
    new_sel && sample_ready_n && pw_cnt_q == 4'h0 |=> !sample_ready_n)
    else $error("ready did not fall on new result");
  chk_ready_release: assert property ( // [R14]
    b_sent && !res_pend_q && !new_sel && pw_cnt_q == 4'h0 |=> sample_ready_n)
    else $error("ready not released after shunt b word");
  chk_ready_hold_low: assert property ( // [R17]
    b_sent && res_pend_q && !sample_ready_n && !new_sel && pw_cnt_q == 4'h0
    |=> !sample_ready_n)
    else $error("ready released with newer results pending");

  cov_timeout: cover property (tmo_hit);
  cov_read_frame: cover property (rd_frame_q && word_done && word_q == 6'h3);
  cov_restart: cover property (conversion_restart);
  cov_ready_pulse: cover property (new_sel && !sample_ready_n);

endmodule : spift_top

`default_nettype wire

// ---- sim/spift_host.sv ----
// Purpose: host model that drives frames on the serial link pins
// Assumes: link half period of four system clocks, 800 ns link period
// Notes: data line flips when idle so a stale bit never looks valid
`timescale 1ns/1ps
`default_nettype none

module spift_host (
  // clock
  input wire logic clk,
  // link pins
  output logic frame_select_n,
  output logic serial_clk,
  output logic serial_din,
  input wire logic serial_dout
);
  logic [23:0] tx [40];
  logic [23:0] rx [40];

  initial
  begin
    frame_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_din = 1'b0;
  end

  // ----------------------------------------------------------------
  // one frame: stall, nb bits msb first, stall, release
  // ----------------------------------------------------------------
  task automatic run(input int nb, input int pre, input int linger);
    @(posedge clk);
    frame_select_n <= 1'b0;
    repeat (4 + pre) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      serial_clk <= 1'b1;
      serial_din <= tx[i / 24][23 - i % 24];
      repeat (4) @(posedge clk);
      serial_clk <= 1'b0;
      rx[i / 24][23 - i % 24] = serial_dout;
      repeat (4) @(posedge clk);
    end
    repeat (linger) @(posedge clk);
    frame_select_n <= 1'b1;
    serial_din <= ~serial_din;
    repeat (8) @(posedge clk);
  endtask : run
endmodule : spift_host

`default_nettype wire

// ---- sim/spift_tb_top.sv ----
// Purpose: self-checking bench for the serial frame supervisor
// Assumes: frame timeout shortened to 1500 clocks
// Notes: expected words are built from package constants, local constants and literal values
`timescale 1ns/1ps
`default_nettype none

module spift_tb_top
  import spift_pkg::*;
;
  localparam logic [15:0] IDENT = 16'h3c96; // arbitrary value
  localparam logic [15:0] STAT_CLR = 16'hffc8;
  localparam logic [15:0] STAT_OVT = 16'hfdc8;
  logic clk;
  logic rst;
  logic fsel_n, sclk, sdi, sdo, rdy_n, a_done, b_done, mux_we, ovt_en, src_sel, st_clr;
  logic restart, rst_req, lock_req, unlock_req;
  logic [23:0] a_data, b_data;
  logic [3:0] mux_idx;
  logic [15:0] mux_data;
  logic [15:0] cmds [3] = '{LOCK_CMD, UNLOCK_CMD, RESET_CMD};
  int n_errors, n_compared, cycles, n_restart, n_rst, n_lock, n_unlock;

  spift_top #(
    .TIMEOUT_CYC(1500),
    .IDENT_WORD(IDENT)
  ) DUT (
    .clk(clk),
    .rst(rst),
    .frame_select_n(fsel_n),
    .serial_clk(sclk),
    .serial_din(sdi),
    .serial_dout(sdo),
    .sample_ready_n(rdy_n),
    .shunt_a_done(a_done),
    .shunt_a_data(a_data),
    .shunt_b_done(b_done),
    .shunt_b_data(b_data),
    .mux_step_we(mux_we),
    .mux_step_idx(mux_idx),
    .mux_step_data(mux_data),
    .overtime_check_enable(ovt_en),
    .ready_source_select(src_sel),
    .status_clear(st_clr),
    .conversion_restart(restart),
    .device_reset_req(rst_req),
    .lock_req(lock_req),
    .unlock_req(unlock_req)
  );

  spift_host host (
    .clk(clk),
    .frame_select_n(fsel_n),
    .serial_clk(sclk),
    .serial_din(sdi),
    .serial_dout(sdo)
  );

  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    n_restart <= n_restart + int'(restart);
    n_rst <= n_rst + int'(rst_req);
    n_lock <= n_lock + int'(lock_req);
    n_unlock <= n_unlock + int'(unlock_req);
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rdy(input logic e);
    #1;
    check({23'h0, rdy_n}, {23'h0, e});
  endtask : rdy

  task automatic frame(input logic [15:0] cmd, input logic [23:0] w2, input int nb,
                       input int pre = 0, input int linger = 0);
    for (int i = 0; i < 40; i++)
      host.tx[i] = 24'h000000;
    host.tx[0] = {cmd, 8'h00};
    host.tx[2] = w2;
    host.run(nb, pre, linger);
  endtask : frame

  task automatic conv(input logic [1:0] sel, input logic [23:0] a, input logic [23:0] b);
    @(posedge clk);
    a_data <= a;
    b_data <= b;
    a_done <= sel[0];
    b_done <= sel[1];
    @(posedge clk);
    a_done <= 1'b0;
    b_done <= 1'b0;
  endtask : conv

  task automatic clr();
    @(posedge clk);
    st_clr <= 1'b1;
    @(posedge clk);
    st_clr <= 1'b0;
  endtask : clr

  task automatic mux(input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk);
    mux_we <= 1'b1;
    mux_idx <= idx;
    mux_data <= d;
    @(posedge clk);
    mux_we <= 1'b0;
  endtask : mux

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {a_done, b_done, mux_we, src_sel, st_clr} = 5'h00;
    {a_data, b_data, mux_idx, mux_data} = '0;
    ovt_en = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    frame(NOOP_CMD, 0, 96);
    check(host.rx[0], {STAT_HI_RST, 8'h00});
    rdy(1'b1);
    clr();
    frame(NOOP_CMD, 0, 96);
    check(host.rx[0], {STAT_CLR, 8'h00});
    @(posedge clk);
    src_sel <= 1'b1;
    conv(2'b01, 24'h1a1a1a, 24'h1b1b1b);
    rdy(1'b1);
    conv(2'b10, 24'h1a1a1a, 24'h1b1b1b);
    rdy(1'b0);
    frame(NOOP_CMD, 0, 48);
    check(host.rx[1], 24'h1a1a1a);
    rdy(1'b0);
    repeat (2)
    begin
      frame(NOOP_CMD, 0, 96);
      check(host.rx[2], 24'h1b1b1b);
      rdy(1'b1);
    end
    conv(2'b11, 24'h2a2a2a, 24'h2b2b2b);
    repeat (2) @(posedge clk);
    conv(2'b11, 24'h3a3a3a, 24'h3b3b3b);
    repeat (2) @(posedge clk);
    rdy(1'b1);
    repeat (5) @(posedge clk);
    rdy(1'b0);
    fork
      frame(NOOP_CMD, 0, 96);
      begin
        repeat (400) @(posedge clk);
        conv(2'b11, 24'h4a4a4a, 24'h4b4b4b);
      end
    join
    check(host.rx[2], 24'h3b3b3b);
    rdy(1'b0);
    frame(NOOP_CMD, 0, 96);
    check(host.rx[2], 24'h4b4b4b);
    rdy(1'b1);
    mux(4'h0, 16'h1234);
    mux(4'hf, 16'hbeef);
    frame(16'ha3e1, 0, 96);
    frame(NOOP_CMD, 0, 96);
    check(host.rx[1], 24'hbeef1f);
    check(host.rx[2], 24'h000000);
    conv(2'b11, 24'h5a5a5a, 24'h5b5b5b);
    frame(16'ha001, 0, 48, 0, 2000);
    rdy(1'b0);
    frame(NOOP_CMD, 0, 96);
    check(host.rx[0], {STAT_OVT, 8'h00});
    check(host.rx[1], {IDENT, 8'h00});
    check(host.rx[2], {STAT_OVT, 8'h01});
    frame(16'h6120, {RESTART_MASK, 8'h00}, 72, 0, 2000);
    rdy(1'b1);
    check(24'(n_restart), 24'd0);
    fork
      frame(16'h6120, {RESTART_MASK, 8'h00}, 96);
      begin
        repeat (650) @(posedge clk);
        conv(2'b10, 24'h5a5a5a, 24'h5b5b5b);
      end
    join
    check(24'(n_restart), 24'd1);
    rdy(1'b1);
    frame(NOOP_CMD, 0, 96);
    check(host.rx[2], 24'h5b5b5b);
    clr();
    ovt_en <= 1'b0;
    frame(16'ha21f, 0, 96);
    frame(NOOP_CMD, 0, 816);
    check(host.rx[1], 24'h123410);
    check(host.rx[16], 24'hbeef1f);
    check(host.rx[17], 24'h000000);
    frame(NOOP_CMD, 0, 96);
    check(host.rx[0], {STAT_CLR, 8'h00});
    ovt_en <= 1'b1;
    foreach (cmds[i])
      frame(cmds[i], 0, 96, 0, (i == 2) ? 2000 : 0);
    check(24'(n_rst), 24'd1);
    check(24'(n_lock + n_unlock), 24'd2);
    frame(RESET_CMD, 0, 72, 0, 2000);
    check(host.rx[0], {STAT_OVT, 8'h00});
    check(24'(n_rst), 24'd1);
    frame(LOCK_CMD, 0, 48, 2000, 0);
    check(24'(n_lock), 24'd1);
    frame(LOCK_CMD, 0, 48, 0, 2000);
    check(24'(n_lock), 24'd2);
    end_sim();
  end
endmodule : spift_tb_top

`default_nettype wire
